/* File: verilog/aan_annunciator.sv */
// Eight-channel alarm annunciator core with Avalon-MM register slave
//
// Functional notes
// - Eight independent alarm channels, each with selectable fault sense.
// - Polarity bit set: low input is fault; clear: high input is fault.
// - Indications follow channel state with no extra latency beyond alarm handling.
// - Direction bit picks direct or inverted indication outputs.
// - New fault blinks its indicator and raises group alarm; relay output follows once alarm has held the relay delay.
// - Alarm stays latched after the fault disappears.
// - Only the acknowledge input clears a latched alarm.
// - Acknowledge drops group alarm; persisting faults show steady, then dark.
// - Later fault blinks again and re-raises group alarm; acked stay steady.
// - Base delay: 11=0.5s, 10=1s, 01=2s, 00=4s (switch three, four).
// - One input delay serves all eight channels.
// - Extended: input delay 1 to 8 s, relay delay 0 to 15 s.
// - Test lights indications; also the alarm unless test scope bit set.
// - Three group outputs: direct, inverted open collector and relay.
// - Relay drive is released while alarm is active past the relay delay, fail-safe.
// - Test asserts while its contact is closed (high); acknowledge acts only on the closing edge.
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module aan_annunciator
    import aan_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  fault_in,
    input  wire logic        ack_pin,
    input  wire logic        test_pin,
    output logic [7:0]       ind_out,
    output logic             grp_oc,
    output logic             grp_oc_inv,
    output logic             relay_drive
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                res[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return res;
    endfunction

    // Whole seconds to milliseconds
    function automatic logic [15:0] sec_to_ms(input logic [3:0] sec);
        logic [19:0] prod;
        prod = {16'h0000, sec} * {4'h0, MS_PER_S};
        return prod[15:0];
    endfunction

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

    // ****************************************************************
    // Register bus slave
    // ****************************************************************
    logic [31:0] ctrl_r;
    logic [7:0]  pol_r;
    logic        bus_ack_r;
    logic [31:0] rdata_r;
    logic [31:0] stat_word;
    logic        relay_alarm_r;

    wire         bus_req  = avs_read | avs_write;
    wire         bus_take = bus_req & ~bus_ack_r;   // Answer after one wait cycle
    wire         wr_ctrl  = bus_take & avs_write & (avs_address == REG_CTRL);
    wire         wr_pol   = bus_take & avs_write & (avs_address == REG_POL);
    wire [31:0]  ctrl_nxt = wr_ctrl ?
                            (lane_merge(ctrl_r, avs_writedata, avs_byteenable) & CTRL_MASK)
                            : ctrl_r;
    wire [31:0]  pol_word = lane_merge({24'h000000, pol_r}, avs_writedata, avs_byteenable);
    wire [7:0]   pol_nxt  = wr_pol ? pol_word[7:0] : pol_r;
    wire [31:0]  rd_sel   = (avs_address == REG_CTRL) ? ctrl_r :
                            (avs_address == REG_POL)  ? {24'h000000, pol_r} :
                            (avs_address == REG_STAT) ? stat_word : 32'h0000_0000;

    assign avs_waitrequest = bus_take;
    assign avs_readdata    = rdata_r;

    // Unmapped reads return zero, unmapped writes are dropped
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ctrl_r    <= CTRL_RST;
            pol_r     <= POL_RST;
            bus_ack_r <= 1'b0;
            rdata_r   <= 32'h0000_0000;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            pol_r     <= pol_nxt;
            bus_ack_r <= bus_take;
            rdata_r   <= (bus_take & avs_read) ? rd_sel : rdata_r;
        end
    end

    // Control fields
    wire         dir_direct  = ctrl_r[CTRL_DIR_BIT];
    wire         test_scope  = ctrl_r[CTRL_SCOPE_BIT];
    wire [1:0]   dsel        = ctrl_r[CTRL_DSEL_LSB +: 2];
    wire         ext_mode    = ctrl_r[CTRL_EXT_BIT];
    wire [2:0]   ext_in_sec  = ctrl_r[CTRL_EIN_LSB +: 3];
    wire [3:0]   rly_sec     = ctrl_r[CTRL_RLY_LSB +: 4];

    // ****************************************************************
    // Timebase and shared blink
    // ****************************************************************
    logic [15:0] tick_cnt_r;
    logic        tick_r;
    logic [15:0] blink_cnt_r;
    logic        blink_r;

    wire         tick_wrap  = (tick_cnt_r == TICK_LAST);
    wire         blink_wrap = tick_r && (blink_cnt_r == BLINK_HALF_MS - 16'h0001);

    // One toggle for all channels keeps every flashing lamp in step
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            tick_cnt_r  <= 16'h0000;
            tick_r      <= 1'b0;
            blink_cnt_r <= 16'h0000;
            blink_r     <= 1'b0;
        end
        else
        begin
            tick_cnt_r  <= tick_wrap ? 16'h0000 : tick_cnt_r + 16'h0001;
            tick_r      <= tick_wrap;
            blink_cnt_r <= blink_wrap ? 16'h0000 :
                           (tick_r ? blink_cnt_r + 16'h0001 : blink_cnt_r);
            blink_r     <= blink_wrap ? ~blink_r : blink_r;
        end
    end

    // ****************************************************************
    // Input delay selection and channel qualifiers
    // ****************************************************************
    logic [15:0] base_dly_ms;
    logic [7:0]  fault_q;

    // Switch three off with four on is taken as the 2 s setting
    assign base_dly_ms = (dsel == DSEL_0P5) ? DLY_0P5_MS :
                         (dsel == DSEL_1P0) ? DLY_1P0_MS :
                         (dsel == DSEL_2P0) ? DLY_2P0_MS : DLY_4P0_MS;
    wire [15:0]  in_dly_ms  = ext_mode ? sec_to_ms({1'b0, ext_in_sec} + 4'h1)
                                       : base_dly_ms;
    wire [15:0]  rly_dly_ms = ext_mode ? sec_to_ms(rly_sec) : 16'h0000;

    // Same delay fans out to every channel
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
        aan_chan_filter u_filter (
            .core_clk (core_clk),
            .srst     (srst),
            .tick     (tick_r),
            .pin_in   (fault_in[ch]),
            .polarity (pol_r[ch]),
            .delay_ms (in_dly_ms),
            .fault_q  (fault_q[ch])
        );
    end

    // ****************************************************************
    // Acknowledge and test pins
    // ****************************************************************
    logic        ack_s1_r;
    logic        ack_s2_r;
    logic        ack_d_r;
    logic        test_s1_r;
    logic        test_s2_r;

    // Closed contact reads high; only the press edge acknowledges
    wire         ack_evt  = ack_s2_r & ~ack_d_r;
    wire         test_act = test_s2_r;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ack_s1_r  <= 1'b0;
            ack_s2_r  <= 1'b0;
            ack_d_r   <= 1'b0;
            test_s1_r <= 1'b0;
            test_s2_r <= 1'b0;
        end
        else
        begin
            ack_s1_r  <= ack_pin;
            ack_s2_r  <= ack_s1_r;
            ack_d_r   <= ack_s2_r;
            test_s1_r <= test_pin;
            test_s2_r <= test_s1_r;
        end
    end

    // ****************************************************************
    // Latch and acknowledge per channel
    // ****************************************************************
    logic [7:0]  alm_r;
    logic [7:0]  ackd_r;

    // New fault: qualified, not latched and not already acknowledged
    wire [7:0]   new_flt  = fault_q & ~alm_r & ~ackd_r;
    // A fault on the acknowledge cycle still latches: set wins
    wire [7:0]   alm_nxt  = (alm_r & ~{8{ack_evt}}) | new_flt;
    // Acked channels stay steady until their fault clears
    wire [7:0]   ackd_nxt = fault_q & (ackd_r | (alm_r & {8{ack_evt}}));
    wire         grp_alm  = |alm_r;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            alm_r  <= 8'h00;
            ackd_r <= 8'h00;
        end
        else
        begin
            alm_r  <= alm_nxt;
            ackd_r <= ackd_nxt;
        end
    end

    // ****************************************************************
    // Relay output delay
    // ****************************************************************
    logic [15:0] rly_cnt_r;

    // Relay follows the group alarm only once it has held the delay
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rly_cnt_r     <= 16'h0000;
            relay_alarm_r <= 1'b0;
        end
        else
        begin
            rly_cnt_r     <= !grp_alm ? 16'h0000 :
                             (tick_r && rly_cnt_r < rly_dly_ms) ? rly_cnt_r + 16'h0001
                                                                : rly_cnt_r;
            relay_alarm_r <= grp_alm && (rly_cnt_r >= rly_dly_ms);
        end
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    logic [7:0]  ind_r;
    logic        oc_r;
    logic        oci_r;
    logic        relay_r;

    wire         test_alm  = test_act & ~test_scope;
    wire [7:0]   ind_act   = (alm_r & {8{blink_r}}) | ackd_r | {8{test_act}};
    wire [7:0]   ind_nxt   = dir_direct ? ind_act : ~ind_act;
    wire         grp_any   = grp_alm | test_alm;
    // Drive released on alarm, so a dead supply also reads as alarm
    wire         relay_nxt = ~(relay_alarm_r | test_alm);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ind_r   <= 8'h00;
            oc_r    <= 1'b0;
            oci_r   <= 1'b0;
            relay_r <= 1'b0;
        end
        else
        begin
            ind_r   <= ind_nxt;
            oc_r    <= grp_any;
            oci_r   <= ~grp_any;
            relay_r <= relay_nxt;
        end
    end

    assign ind_out     = ind_r;
    assign grp_oc      = oc_r;
    assign grp_oc_inv  = oci_r;
    assign relay_drive = relay_r;

    assign stat_word = {5'h00, test_act, relay_alarm_r, grp_alm, ackd_r, alm_r, fault_q};

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    AST_LATCH_HOLD: assert property (
        !ack_evt |=> ((alm_r & $past(alm_r)) == $past(alm_r)))
        else $error("latched alarm lost without acknowledge");

    AST_ACK_CLEAR: assert property (
        ack_evt && (new_flt == 8'h00) |=> (alm_r == 8'h00))
        else $error("acknowledge left an alarm latched");

    AST_ACK_STEADY: assert property (
        ack_evt |=> ((ackd_r & $past(alm_r & fault_q)) == $past(alm_r & fault_q)))
        else $error("acknowledged persisting fault not held steady");

    AST_GROUP_RAISE: assert property (
        (alm_r != 8'h00) |=> grp_oc && !grp_oc_inv)
        else $error("group outputs not in alarm while latched");

    AST_INVERT: assert property (
        !dir_direct && (ind_act == 8'h00) |=> (ind_out == 8'hFF))
        else $error("inverted output not active in normal state");

    AST_STEADY_LIT: assert property (
        dir_direct && !test_act |=> ((ind_out & $past(ackd_r)) == $past(ackd_r)))
        else $error("acknowledged channel indication not steady lit");

    AST_RELAY_SAFE: assert property (
        relay_alarm_r |=> !relay_drive)
        else $error("relay energised during alarm");

    AST_TEST_SCOPE: assert property (
        test_act && test_scope && !relay_alarm_r |=> relay_drive)
        else $error("indication-only test touched relay");

    AST_BLINK_STEP: assert property (
        $changed(blink_r) |-> $past(blink_cnt_r) == BLINK_HALF_MS - 16'h0001)
        else $error("blink toggled off its period");

    AST_BUS_WAIT: assert property (
        bus_req && !bus_ack_r |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    COV_ALARM: cover property ($rose(grp_alm));
    COV_ACK_PERSIST: cover property (ack_evt && (alm_r & fault_q) != 8'h00);
    COV_REALARM: cover property ((ackd_r != 8'h00) && (new_flt != 8'h00));
    COV_TEST: cover property (test_act && !test_scope);

endmodule
`default_nettype wire

/* File: verilog/aan_pkg.sv */
// Shared constants and register map of the eight-channel alarm annunciator
package aan_pkg;

    // ****************************************************************
    // Clock and timebase
    // ****************************************************************
    localparam int          CLK_HZ      = 20_000_000;
    localparam int          TICK_US     = 1000;                      // Millisecond timebase
    localparam int          TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int          NUM_CH      = 8;

    // ****************************************************************
    // Times in milliseconds, counted in timebase ticks
    // ****************************************************************
    localparam logic [15:0] DLY_0P5_MS    = 16'h01F4;              // 500 ms
    localparam logic [15:0] DLY_1P0_MS    = 16'h03E8;              // 1000 ms
    localparam logic [15:0] DLY_2P0_MS    = 16'h07D0;              // 2000 ms
    localparam logic [15:0] DLY_4P0_MS    = 16'h0FA0;              // 4000 ms
    localparam logic [15:0] MS_PER_S      = 16'h03E8;
    localparam logic [15:0] BLINK_HALF_MS = 16'h01F4;              // 1 Hz flash

    // ****************************************************************
    // Input delay select codes, switch three in bit 1, four in bit 0
    // ****************************************************************
    localparam logic [1:0]  DSEL_0P5 = 2'h3;
    localparam logic [1:0]  DSEL_1P0 = 2'h2;
    localparam logic [1:0]  DSEL_2P0 = 2'h1;
    localparam logic [1:0]  DSEL_4P0 = 2'h0;

    // ****************************************************************
    // Register offsets (byte addresses) and fields
    // ****************************************************************
    localparam logic [3:0]  REG_CTRL = 4'h0;
    localparam logic [3:0]  REG_POL  = 4'h4;
    localparam logic [3:0]  REG_STAT = 4'h8;

    localparam int          CTRL_DIR_BIT   = 0;   // output_direction_select
    localparam int          CTRL_SCOPE_BIT = 1;   // test_scope_select
    localparam int          CTRL_DSEL_LSB  = 2;   // input_delay_select, 2 bits
    localparam int          CTRL_EXT_BIT   = 4;   // extended variant
    localparam int          CTRL_EIN_LSB   = 8;   // extended input delay, seconds - 1
    localparam int          CTRL_RLY_LSB   = 16;  // relay delay, seconds

    localparam int          STAT_FLT_LSB = 0;
    localparam int          STAT_ALM_LSB = 8;
    localparam int          STAT_ACK_LSB = 16;
    localparam int          STAT_GRP_BIT = 24;
    localparam int          STAT_RLY_BIT = 25;
    localparam int          STAT_TST_BIT = 26;

    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] CTRL_MASK = 32'h000F_071F;
    localparam logic [7:0]  POL_RST  = 8'h00;

endpackage

/* File: verilog/aan_chan_filter.sv */
// Per-channel input synchroniser, polarity and persistence qualifier
`timescale 1ns/1ps
`default_nettype none
module aan_chan_filter
    import aan_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        tick,
    input  wire logic        pin_in,
    input  wire logic        polarity,
    input  wire logic [15:0] delay_ms,
    output logic             fault_q
);

    logic        sync1_r;
    logic        sync2_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        qual_r;
    logic        qual_nxt;
    wire         cond = polarity ? ~sync2_r : sync2_r;

    // Count ticks while the fault condition holds; any gap restarts it
    assign cnt_nxt  = !cond ? 16'h0000 :
                      (tick && cnt_r < delay_ms) ? cnt_r + 16'h0001 : cnt_r;
    assign qual_nxt = cond && (cnt_r >= delay_ms);

    // Pin crosses in through two flops before anything reads it
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            cnt_r   <= 16'h0000;
            qual_r  <= 1'b0;
        end
        else
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            cnt_r   <= cnt_nxt;
            qual_r  <= qual_nxt;
        end
    end

    assign fault_q = qual_r;

    // Qualified fault drops at once when the condition goes away
    AST_QUAL_DROP: assert property (@(posedge core_clk) disable iff (srst)
        !cond |=> !qual_r)
        else $error("fault stayed qualified after condition left");

    // A rising qualified fault needs a full delay of held condition
    AST_QUAL_RISE: assert property (@(posedge core_clk) disable iff (srst)
        $rose(qual_r) |-> $past(cond) && ($past(cnt_r) >= $past(delay_ms)))
        else $error("fault qualified before the delay expired");

endmodule
`default_nettype wire

/* File: dv/aan_field_model.sv */
// Field side model: alarm contacts and the test and acknowledge buttons
`timescale 1ns/1ps
`default_nettype none
module aan_field_model
(
    input  wire logic       core_clk,
    input  wire logic [7:0] contact_cmd,
    input  wire logic       ack_cmd,
    input  wire logic       test_cmd,
    output var logic [7:0]  fault_in = 8'h00,
    output var logic        ack_pin = 1'b0,
    output var logic        test_pin = 1'b0
);
    // ********************
    // Contacts
    // ********************
    // Closed contact reads high; contacts move only just after an edge
    always @(posedge core_clk)
    begin
        fault_in <= contact_cmd;
        ack_pin  <= ack_cmd;
        test_pin <= test_cmd;
    end
endmodule
`default_nettype wire

/* File: dv/aan_annunciator_tb.sv */
// Self-checking bench of the alarm annunciator core
`timescale 1ns/1ps
`default_nettype none
module aan_annunciator_tb
    import aan_pkg::*;
;
    localparam int TK = 4;                        // Short timebase keeps the run brief
    localparam int D5 = int'(DLY_0P5_MS) * TK;
    localparam int BH = int'(BLINK_HALF_MS) * TK;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, ack_pin, test_pin, grp_oc, grp_oc_inv, relay_drive;
    logic [7:0]  fault_in, ind_out, blk;
    logic [7:0]  contact_cmd = 8'h00;
    logic        ack_cmd = 1'b0;
    logic        test_cmd = 1'b0;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // Rows: polarity, contacts, expected qualified faults
    logic [23:0] rows [5] = '{24'h00_01_01, 24'h00_80_80, 24'hFF_FE_01, 24'hF0_5A_AA,
                              24'h0F_0F_00};
    logic [15:0] dly [4] = '{DLY_4P0_MS, DLY_2P0_MS, DLY_1P0_MS, DLY_0P5_MS};

    // ********************
    // Harness and tasks
    // ********************
    // Free running 20 MHz clock
    always #25 core_clk = ~core_clk;

    aan_annunciator #(.TICK_CYC(TK)) i_aan_annunciator
    (
        .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fault_in(fault_in), .ack_pin(ack_pin),
        .test_pin(test_pin), .ind_out(ind_out), .grp_oc(grp_oc),
        .grp_oc_inv(grp_oc_inv), .relay_drive(relay_drive)
    );

    aan_field_model i_aan_field_model
    (
        .core_clk(core_clk), .contact_cmd(contact_cmd), .ack_cmd(ack_cmd),
        .test_cmd(test_cmd), .fault_in(fault_in), .ack_pin(ack_pin), .test_pin(test_pin)
    );

    // Verdict in one place
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Bus access; held until waitrequest is sampled low, only the hang guard ends a stuck wait
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge core_clk);
            n++;
        end
        rd = avs_readdata;
        chk("bus wait", 1, n);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Short press of the acknowledge button
    task automatic ack();
        ack_cmd <= 1'b1;
        wt(6);
        ack_cmd <= 1'b0;
        wt(6);
    endtask

    // Hang guard, longer than the whole sequence
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 100000)
        begin
            n_fail++;
            final_report();
        end
    end

    // Main sequence
    initial
    begin
        wt(5);
        srst <= 1'b0;
        wt(2);
        chk("idle outs", 3'b011, {grp_oc, grp_oc_inv, relay_drive});
        bus(0, REG_CTRL, 0);
        chk("ctrl rst", CTRL_RST, rd);
        bus(0, REG_POL, 0);
        chk("pol rst", {24'h0, POL_RST}, rd);
        bus(1, 4'hC, 32'hFFFF_FFFF);
        bus(0, 4'hC, 0);
        chk("unmapped", 0, rd);
        bus(1, REG_CTRL, 32'hFFFF_FFFF);
        bus(0, REG_CTRL, 0);
        chk("ctrl mask", CTRL_MASK, rd);
        // Only lane one written: the other lanes must keep their bits
        avs_byteenable <= 4'h2;
        bus(1, REG_CTRL, 32'h0000_0000);
        avs_byteenable <= 4'hF;
        bus(0, REG_CTRL, 0);
        chk("lanes", 32'h000F_001F, rd);
        bus(1, REG_CTRL, 32'h0000_000D);
        $display("test registers done");
        foreach (rows[i])
        begin
            contact_cmd <= rows[i][15:8];
            bus(1, REG_POL, {24'h0, rows[i][23:16]});
            wt(D5 + 40);
            bus(0, REG_STAT, 0);
            chk("faults", rows[i][7:0], rd[7:0]);
            chk("group", |rows[i][7:0], grp_oc);
            contact_cmd <= rows[i][23:16];
            wt(D5 + 40);
            ack();
            chk("cleared", 0, {grp_oc, ind_out});
        end
        $display("test table done");
        bus(1, REG_POL, 32'h0);
        contact_cmd <= 8'h01;
        wt(D5 - 60);
        contact_cmd <= 8'h00;
        wt(D5 + 40);
        chk("short pulse", 0, grp_oc);
        $display("test pulse done");
        // Latch, blink, acknowledge and re-alarm
        contact_cmd <= 8'h03;
        wt(D5 + 40);
        chk("alarm outs", 3'b100, {grp_oc, grp_oc_inv, relay_drive});
        bus(0, REG_STAT, 0);
        chk("stat alarm", 32'h0300_0303, rd);
        contact_cmd <= 8'h02;
        wt(40);
        chk("latched", 1, grp_oc);
        blk = ind_out;
        chk("in step", {2{blk[0]}}, blk[1:0]);
        wt(BH);
        chk("blink", {~blk[1], ~blk[0]}, ind_out[1:0]);
        ack();
        chk("acked", 4'h6, {grp_oc, relay_drive, ind_out[1:0]});
        wt(BH);
        chk("steady", 2'h2, ind_out[1:0]);
        bus(0, REG_STAT, 0);
        chk("stat acked", 32'h0002_0002, rd);
        contact_cmd <= 8'h06;
        wt(D5 + 40);
        blk = ind_out;
        wt(BH);
        chk("re-alarm", {1'b1, ~blk[2], 2'h2}, {grp_oc, ind_out[2:0]});
        contact_cmd <= 8'h00;
        wt(40);
        ack();
        $display("test latch done");
        bus(1, REG_CTRL, 32'h0000_000C);
        wt(4);
        chk("inverted", 8'hFF, ind_out);
        for (int s = 0; s < 2; s++)
        begin
            bus(1, REG_CTRL, 32'h0000_000D | (s << 1));
            test_cmd <= 1'b1;
            wt(8);
            chk("test", {8'hFF, s[0] == 1'b0, s[0]}, {ind_out, grp_oc, relay_drive});
            bus(0, REG_STAT, 0);
            chk("stat test", 32'h0400_0000, rd);
            test_cmd <= 1'b0;
            wt(8);
        end
        $display("test modes done");
        for (int k = 0; k < 4; k++)
        begin
            bus(1, REG_CTRL, 32'h0000_0001 | (k << 2));
            contact_cmd <= 8'h01;
            wt(int'(dly[k]) * TK - 10);
            chk("early", 0, grp_oc);
            wt(30);
            chk("on time", 1, grp_oc);
            contact_cmd <= 8'h00;
            wt(10);
            ack();
        end
        $display("test delays done");
        bus(1, REG_CTRL, 32'h0001_0011);
        contact_cmd <= 8'h01;
        wt(1000 * TK - 10);
        chk("ext early", 0, grp_oc);
        wt(30);
        chk("ext grp", 2'h3, {grp_oc, relay_drive});
        wt(1000 * TK + 10);
        chk("ext relay", 2'h2, {grp_oc, relay_drive});
        $display("test extended done");
        // Reset in mid-alarm: all drives drop, relay released, control back to default
        srst <= 1'b1;
        wt(5);
        chk("reset outs", 11'h000, {ind_out, grp_oc, grp_oc_inv, relay_drive});
        srst <= 1'b0;
        wt(2);
        chk("reset idle", 3'b011, {grp_oc, grp_oc_inv, relay_drive});
        bus(0, REG_CTRL, 0);
        chk("reset ctrl", CTRL_RST, rd);
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
